/* rtl/adcc_pkg.sv */
/*
  Constants shared by the conversion control block: register indices, field
  positions, reset values, channel codes, state codes and timing figures.
  Assumes an 8-bit register port and a 10-bit successive-approximation core.
*/
// How it works
// (RULE1) Software makes the chosen pin an analog input before converting.
// (RULE2) Software picks clock, reference and channel, then enables the converter.
// (RULE3) Software clears the flag before enabling the converter interrupt chain.
// (RULE4) Software may keep global interrupts off to resume in line after wake.
// (RULE5) Software waits the acquisition interval before requesting a conversion.
// (RULE6) Writing one to the start bit begins a conversion.
// (RULE7) The start bit reads one while converting and zero once finished.
// (RULE8) Software clears the conversion flag after reading the result.
// (RULE9) Control layout: channel bits 6-2, start bit 1, enable bit 0, bit 7 zero.
// (RULE10) Channel codes 0-3 and 8-13 route inputs; other codes connect nothing.
// (RULE11) Completion clears start, sets the flag and loads both result registers.
// (RULE12) Clearing start early aborts; missing bits copy the last converted bit.
// (RULE13) Software avoids setting start in the write that enables the converter.
// (RULE14) Left justified, the high result register holds result bits 9 to 2.
// (RULE15) A reserved channel still converts, but the result means nothing.
package adcc_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int RES_W = 10;
  localparam int CHS_W = 5;
  localparam int NUM_AIN = 14;
  localparam int TAD_W = 8;
  localparam int BIT_W = 4;

  // Register indices on the register port.
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_RES_HIGH = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_RES_LOW = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_MASK = 3'h5;

  // Control register fields.
  localparam int CTL_EN_BIT = 0;
  localparam int CTL_GO_BIT = 1;
  localparam int CTL_CHS_LSB = 2;

  // Configuration register fields.
  localparam int CFG_REF_LSB = 0;
  localparam int CFG_REF_W = 2;
  localparam int CFG_DIV_LSB = 4;
  localparam int CFG_DIV_W = 3;
  localparam int CFG_FMT_BIT = 7;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 8'hF3;

  // Status and mask fields.
  localparam int ST_DONE_BIT = 0;
  localparam int ST_ABORT_BIT = 1;
  localparam int ST_W = 2;

  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;
  localparam logic [ST_W-1:0] ST_RESET = 2'h0;

  // Channel code ranges that reach an analog input.
  localparam logic [CHS_W-1:0] CHS_LOW_LAST = 5'h03;
  localparam logic [CHS_W-1:0] CHS_HIGH_FIRST = 5'h08;
  localparam logic [CHS_W-1:0] CHS_HIGH_LAST = 5'h0D;

  // Conversion clock dividers by select code.
  localparam logic [CFG_DIV_W-1:0] DIV_2 = 3'h0;
  localparam logic [CFG_DIV_W-1:0] DIV_4 = 3'h4;
  localparam logic [CFG_DIV_W-1:0] DIV_8 = 3'h1;
  localparam logic [CFG_DIV_W-1:0] DIV_16 = 3'h5;
  localparam logic [CFG_DIV_W-1:0] DIV_32 = 3'h2;
  localparam logic [CFG_DIV_W-1:0] DIV_64 = 3'h6;

  // Comparator synchroniser depth, added to each bit period.
  localparam logic [TAD_W-1:0] SYNC_LAT = 8'h02;
  localparam logic [BIT_W-1:0] MSB_INDEX = 4'h9;

  typedef enum logic [1:0] {
    ADCC_IDLE = 2'b00,
    ADCC_SAMPLE = 2'b01,
    ADCC_BITS = 2'b10
  } adcc_state_e;

endpackage : adcc_pkg

/* rtl/adcc_sar_if.sv */
/*
  Carrier between the control registers and the approximation engine.
  Assumes both ends share one clock.
*/
interface adcc_sar_if;
  import adcc_pkg::*;

  logic start;
  logic abort;
  logic [TAD_W-1:0] tad_cycles;
  logic done;
  logic aborted;
  logic busy;
  logic [RES_W-1:0] result;

  modport ctrl (output start, output abort, output tad_cycles,
                input done, input aborted, input busy, input result);
  modport engine (input start, input abort, input tad_cycles,
                  output done, output aborted, output busy, output result);
endinterface : adcc_sar_if

/* rtl/adcc_sar.sv */
/*
  Successive-approximation engine: one sample period, then ten bit periods,
  each decided by the synchronised comparator. Assumes an external DAC and
  comparator and a bit period of at least three clocks.
*/
module adcc_sar
  import adcc_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control side.
  adcc_sar_if.engine sif,
  // Analog front end.
  input wire logic comp_in,
  output logic [adcc_pkg::RES_W-1:0] dac_code
);
  import adcc_pkg::*;

  adcc_state_e state_q, state_d;
  logic [TAD_W-1:0] cnt_q, cnt_d;
  logic [BIT_W-1:0] bit_q, bit_d;
  logic [RES_W-1:0] res_q, res_d, out_q, out_d, dac_q, dac_d;
  logic done_q, done_d, abt_q, abt_d;
  logic comp_m_q, comp_s_q;
  logic fill;
  logic period_end;

  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_m_q <= 1'b0;
      comp_s_q <= 1'b0;
    end else begin
      comp_m_q <= comp_in;
      comp_s_q <= comp_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign period_end = (cnt_q == sif.tad_cycles - 8'h01);

  always_comb begin
    state_d = state_q;
    cnt_d = period_end ? '0 : cnt_q + 8'h01;
    bit_d = bit_q;
    res_d = res_q;
    out_d = out_q;
    dac_d = dac_q;
    done_d = 1'b0;
    abt_d = abt_q;
    fill = (bit_q == MSB_INDEX) ? 1'b0 : res_q[bit_q + 4'h1];
    case (state_q)
      ADCC_IDLE: begin
        cnt_d = '0;
        if (sif.start) begin // RULE6
          state_d = ADCC_SAMPLE;
          res_d = '0;
          bit_d = MSB_INDEX;
          dac_d = '0;
        end
      end
      ADCC_SAMPLE: begin
        if (period_end) begin
          state_d = ADCC_BITS;
          dac_d = RES_W'(1) << MSB_INDEX;
        end
      end
      ADCC_BITS: begin
        if (period_end) begin
          res_d[bit_q] = comp_s_q;
          if (bit_q == '0) begin
            state_d = ADCC_IDLE;
            out_d = res_d;
            done_d = 1'b1; // RULE11
            abt_d = 1'b0;
          end else begin
            bit_d = bit_q - 4'h1;
            dac_d = res_d | (RES_W'(1) << bit_d);
          end
        end
      end
      default: state_d = ADCC_IDLE;
    endcase
    if (sif.abort && state_q != ADCC_IDLE) begin
      // Bits not yet decided repeat the most recent decision.
      for (int j = 0; j < RES_W; j++) begin
        if (j <= int'(bit_q)) res_d[j] = (state_q == ADCC_SAMPLE) ? 1'b0 : fill; // RULE12
      end
      state_d = ADCC_IDLE;
      out_d = res_d;
      done_d = 1'b1;
      abt_d = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ADCC_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      res_q <= '0;
      out_q <= '0;
      dac_q <= '0;
      done_q <= 1'b0;
      abt_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      res_q <= res_d;
      out_q <= out_d;
      dac_q <= dac_d;
      done_q <= done_d;
      abt_q <= abt_d;
    end
  end

  assign sif.done = done_q;
  assign sif.aborted = abt_q;
  assign sif.result = out_q;
  assign sif.busy = (state_q != ADCC_IDLE);
  assign dac_code = dac_q;

endmodule // adcc_sar

/* rtl/adcc_top.sv */
/*
  Conversion control block: control, configuration, result, status and mask
  registers on a plain register port, channel routing and the interrupt.
  Assumes a single-master register port with reads answered one cycle later.
*/
// Chosen here: strobed register access and the register offsets.
module adcc_top
  import adcc_pkg::*;
#(
  parameter logic [adcc_pkg::TAD_W-1:0] FRC_DIV = 8'h20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [adcc_pkg::DATA_W-1:0] reg_rdata,
  // Analog front end.
  input wire logic comp_in,
  output logic [adcc_pkg::RES_W-1:0] dac_code,
  output logic [adcc_pkg::NUM_AIN-1:0] ain_select,
  output logic converter_on,
  output logic [adcc_pkg::CFG_REF_W-1:0] vref_select,
  // Interrupt.
  output logic irq
);
  import adcc_pkg::*;

  adcc_sar_if sif ();

  logic converter_enable_q, converter_enable_d;
  logic convert_start_alias_q, convert_start_alias_d;
  logic [CHS_W-1:0] channel_select_q, channel_select_d;
  logic [DATA_W-1:0] cfg_q, cfg_d;
  logic [DATA_W-1:0] result_high_q, result_high_d;
  logic [DATA_W-1:0] result_low_q, result_low_d;
  logic [ST_W-1:0] status_q, status_d, mask_q, mask_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [NUM_AIN-1:0] ain_q, ain_d;
  logic ctl_wr;
  logic start_req;
  logic stop_req;

  ////////////////////////////////////////////////////////////////////////////

  // Only the documented code ranges reach a pin; any other code leaves every
  // switch open, so the engine still runs but converts a floating node.
  function automatic logic [NUM_AIN-1:0] route_channel(input logic [CHS_W-1:0] chs);
    logic [NUM_AIN-1:0] sel;
    sel = '0;
    if (chs <= CHS_LOW_LAST || (chs >= CHS_HIGH_FIRST && chs <= CHS_HIGH_LAST)) begin
      sel[chs[BIT_W-1:0]] = 1'b1; // RULE10
    end
    return sel; // RULE15
  endfunction

  function automatic logic [TAD_W-1:0] tad_of(input logic [CFG_DIV_W-1:0] code);
    logic [TAD_W-1:0] div;
    case (code)
      DIV_2: div = 8'h02;
      DIV_4: div = 8'h04;
      DIV_8: div = 8'h08;
      DIV_16: div = 8'h10;
      DIV_32: div = 8'h20;
      DIV_64: div = 8'h40;
      default: div = FRC_DIV;
    endcase
    return div + SYNC_LAT;
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  assign ctl_wr = reg_we && (reg_addr == OFS_CONTROL);
  // A start needs the converter to be on in the same written value; a write
  // that leaves start low, or turns the converter off, stops a running one.
  assign start_req = ctl_wr && reg_wdata[CTL_GO_BIT] && reg_wdata[CTL_EN_BIT]
                     && !convert_start_alias_q && !sif.busy; // RULE6
  assign stop_req = ctl_wr && convert_start_alias_q
                    && (!reg_wdata[CTL_GO_BIT] || !reg_wdata[CTL_EN_BIT]); // RULE12

  assign sif.start = start_req;
  assign sif.abort = stop_req;
  assign sif.tad_cycles = tad_of(cfg_q[CFG_DIV_LSB +: CFG_DIV_W]);

  adcc_sar u_sar (
    .clk(clk),
    .rst(rst),
    .sif(sif),
    .comp_in(comp_in),
    .dac_code(dac_code)
  );

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    converter_enable_d = converter_enable_q;
    convert_start_alias_d = convert_start_alias_q;
    channel_select_d = channel_select_q;
    cfg_d = cfg_q;
    mask_d = mask_q;
    if (ctl_wr) begin
      converter_enable_d = reg_wdata[CTL_EN_BIT];
      channel_select_d = reg_wdata[CTL_CHS_LSB +: CHS_W]; // RULE9
    end
    if (start_req) begin
      convert_start_alias_d = 1'b1; // RULE7
    end else if (stop_req) begin
      convert_start_alias_d = 1'b0; // RULE12
    end else if (sif.done && !sif.aborted) begin
      convert_start_alias_d = 1'b0; // RULE11
    end
    if (reg_we && reg_addr == OFS_CONFIG) begin
      cfg_d = reg_wdata & CFG_WRITE_MASK;
    end
    if (reg_we && reg_addr == OFS_MASK) begin
      mask_d = reg_wdata[ST_W-1:0];
    end
    ain_d = route_channel(channel_select_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_enable_q <= 1'b0;
      convert_start_alias_q <= 1'b0;
      channel_select_q <= '0;
      cfg_q <= REG_RESET;
      mask_q <= ST_RESET;
      ain_q <= '0;
    end else begin
      converter_enable_q <= converter_enable_d;
      convert_start_alias_q <= convert_start_alias_d;
      channel_select_q <= channel_select_d;
      cfg_q <= cfg_d;
      mask_q <= mask_d;
      ain_q <= ain_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Results load on completion and on abort; the format is applied at load
  // time, so changing the format later does not reshuffle a stored result.
  // A software write in the loading cycle loses, so no result is ever dropped.
  always_comb begin
    result_high_d = result_high_q;
    result_low_d = result_low_q;
    if (reg_we && reg_addr == OFS_RES_HIGH) begin
      result_high_d = reg_wdata;
    end
    if (reg_we && reg_addr == OFS_RES_LOW) begin
      result_low_d = reg_wdata;
    end
    if (sif.done) begin // RULE11
      if (cfg_q[CFG_FMT_BIT]) begin
        result_high_d = DATA_W'(sif.result[RES_W-1:DATA_W]);
        result_low_d = sif.result[DATA_W-1:0];
      end else begin
        result_high_d = sif.result[RES_W-1:RES_W-DATA_W]; // RULE14
        result_low_d = {sif.result[RES_W-DATA_W-1:0], {(2*DATA_W-RES_W){1'b0}}};
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_high_q <= REG_RESET;
      result_low_q <= REG_RESET;
    end else begin
      result_high_q <= result_high_d;
      result_low_q <= result_low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Write one to clear; a new event in the clearing cycle still sets.
  always_comb begin
    status_d = status_q;
    if (reg_we && reg_addr == OFS_STATUS) begin
      status_d = status_q & ~reg_wdata[ST_W-1:0];
    end
    if (sif.done && !sif.aborted) begin
      status_d[ST_DONE_BIT] = 1'b1; // RULE11
    end
    if (sif.done && sif.aborted) begin
      status_d[ST_ABORT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_q <= ST_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    rdata_d = '0;
    if (reg_re) begin
      case (reg_addr)
        OFS_CONTROL: begin
          rdata_d = '0; // RULE9
          rdata_d[CTL_CHS_LSB +: CHS_W] = channel_select_q;
          rdata_d[CTL_GO_BIT] = convert_start_alias_q; // RULE7
          rdata_d[CTL_EN_BIT] = converter_enable_q;
        end
        OFS_RES_HIGH: rdata_d = result_high_q;
        OFS_RES_LOW: rdata_d = result_low_q;
        OFS_CONFIG: rdata_d = cfg_q;
        OFS_STATUS: rdata_d = DATA_W'(status_q);
        OFS_MASK: rdata_d = DATA_W'(mask_q);
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign ain_select = ain_q;
  assign converter_on = converter_enable_q;
  assign vref_select = cfg_q[CFG_REF_LSB +: CFG_REF_W];
  assign irq = |(status_q & mask_q);

endmodule // adcc_top

/* test/adcc_monitor.sv */
/*
  Port-level assertions for the conversion control block.
  Assumes it is bound to adcc_top and sees only its ports.
*/
module adcc_monitor
  import adcc_pkg::*;
#(
  parameter logic [adcc_pkg::TAD_W-1:0] FRC_DIV = 8'h20
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire logic [adcc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [adcc_pkg::DATA_W-1:0] reg_rdata,
  // Analog front end and interrupt.
  input wire logic comp_in,
  input wire logic [adcc_pkg::RES_W-1:0] dac_code,
  input wire logic [adcc_pkg::NUM_AIN-1:0] ain_select,
  input wire logic converter_on,
  input wire logic [adcc_pkg::CFG_REF_W-1:0] vref_select,
  input wire logic irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_ctl_wr;
    reg_we && reg_addr == OFS_CONTROL;
  endsequence
  sequence s_ctl_rd;
    reg_re && reg_addr == OFS_CONTROL;
  endsequence
  sequence s_go_wr;
    s_ctl_wr and (reg_wdata[1:0] == 2'b11);
  endsequence
  sequence s_stop_wr;
    s_ctl_wr and (!reg_wdata[CTL_GO_BIT]);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!reg_re |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_ctl_top_zero: assert property (s_ctl_rd |=> !reg_rdata[7])
    else $error("control bit 7 read as one");
  a_cfg_gap_zero: assert property (reg_re && reg_addr == OFS_CONFIG |=> reg_rdata[3:2] == 2'b00)
    else $error("config bits 3:2 not zero");
  a_ain_onehot: assert property ($onehot0(ain_select))
    else $error("more than one analog input selected");
  a_ain_reserved: assert property (ain_select[7:4] == 4'h0)
    else $error("reserved channel routed an input");
  a_enable_follow: assert property (s_ctl_wr ##1 !reg_we |=>
    converter_on == $past(reg_wdata[CTL_EN_BIT], 2))
    else $error("converter enable does not follow control bit 0");
  a_vref_follow: assert property (reg_we && reg_addr == OFS_CONFIG ##1 !reg_we |=>
    vref_select == $past(reg_wdata[1:0], 2))
    else $error("reference select does not follow config");
  a_go_reads_set: assert property (s_go_wr ##1 s_ctl_rd |=> reg_rdata[CTL_GO_BIT])
    else $error("start bit not set while converting");
  a_stop_clears: assert property (s_stop_wr ##1 s_ctl_rd |=> !reg_rdata[CTL_GO_BIT])
    else $error("start bit still set after clearing it");
  a_chs_readback: assert property (s_ctl_wr ##1 s_ctl_rd |=>
    reg_rdata[6:2] == $past(reg_wdata[6:2], 2))
    else $error("channel field readback differs");
endmodule // adcc_monitor

bind adcc_top adcc_monitor #(.FRC_DIV(FRC_DIV)) adcc_monitor_i (
  .clk(clk),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_we(reg_we),
  .reg_re(reg_re),
  .reg_rdata(reg_rdata),
  .comp_in(comp_in),
  .dac_code(dac_code),
  .ain_select(ain_select),
  .converter_on(converter_on),
  .vref_select(vref_select),
  .irq(irq)
);

/* test/adcc_tb.sv */
/*
  Self-checking bench for the conversion control block.
  Assumes the bench plays both the software and the analog comparator.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import adcc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic comp_in = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic [RES_W-1:0] dac_code;
  logic [NUM_AIN-1:0] ain_select;
  logic converter_on;
  logic [CFG_REF_W-1:0] vref_select;
  logic irq;
  logic [7:0] d;
  logic [4:0] chs;
  int fail_count = 0;
  int n_compared = 0;
  int vin = 0;
  int n;
  logic irq_seen;
  logic [NUM_AIN-1:0] ain_seen;
  logic on_seen;
  logic [CFG_REF_W-1:0] vref_seen;

  adcc_top #(.FRC_DIV(8'h02)) adcc_top_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
    .comp_in(comp_in), .dac_code(dac_code), .ain_select(ain_select),
    .converter_on(converter_on), .vref_select(vref_select), .irq(irq));

  always #25 clk = ~clk;
  // The analog level sits half a step above vin, so the ideal result is vin exactly.
  always @(posedge clk) comp_in <= (vin >= dac_code);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Tasks are entered just after a rising edge. A write leaves its strobe up so
  // writes can follow back to back; the next read or idle spell takes it down.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
  endtask
  task automatic idle(input int cycles);
    reg_we <= 1'b0;
    repeat (cycles) @(posedge clk);
  endtask
  // Level outputs are captured mid-cycle, at the falling edge beside the read data, never at a rising edge.
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    irq_seen = irq;
    ain_seen = ain_select;
    on_seen = converter_on;
    vref_seen = vref_select;
    @(posedge clk);
  endtask
  function automatic logic [13:0] ain_exp(input int c);
    return (c <= 3 || (c >= 8 && c <= 13)) ? 14'h0001 << c : 14'h0000;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hd3fc));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0], d);
      chk("reset value", 16'h0000, {8'h00, d});
    end
    $display("reset values done");
    for (int i = 0; i < 20; i++) begin
      chs = (i < 16) ? i[4:0] : 5'($urandom % 32);
      wr(OFS_CONTROL, {1'b0, chs, 2'b01});
      rd(OFS_CONTROL, d);
      chk("control", {8'h00, 1'b0, chs, 2'b01}, {8'h00, d});
      chk("ain_select", {2'b00, ain_exp(chs)}, {2'b00, ain_seen});
      chk("converter_on", 16'h0001, {15'h0, on_seen});
    end
    $display("channel table done");
    for (int f = 0; f < 2; f++) begin
      vin = $urandom % 1024;
      chs = f ? 5'h02 : 5'h07;
      wr(OFS_CONFIG, {f[0], DIV_8, 2'b11, 2'(f + 1)});
      rd(OFS_CONFIG, d);
      chk("config", {8'h00, f[0], DIV_8, 2'b00, 2'(f + 1)}, {8'h00, d});
      wr(OFS_STATUS, 8'h03);
      wr(OFS_MASK, {7'h00, f[0]});
      wr(OFS_CONTROL, {1'b0, chs, 2'b01});
      idle(4);
      wr(OFS_CONTROL, {1'b0, chs, 2'b11});
      rd(OFS_CONTROL, d);
      chk("start bit", 16'h0001, {15'h0, d[1]});
      for (n = 0; n < 200 && d[1] !== 1'b0; n++) rd(OFS_CONTROL, d);
      if (n == 200) begin
        fail_count++;
        end_of_test();
      end
      rd(OFS_STATUS, d);
      chk("status", 16'h0001, {8'h00, d});
      chk("irq", {15'h0, f[0]}, {15'h0, irq_seen});
      rd(OFS_RES_HIGH, d);
      chk("result_high", f ? 16'(vin >> 8) : 16'(vin >> 2), {8'h00, d});
      rd(OFS_RES_LOW, d);
      chk("result_low", f ? 16'(vin & 255) : 16'((vin & 3) << 6), {8'h00, d});
      wr(OFS_STATUS, 8'h01);
      rd(OFS_STATUS, d);
      chk("status cleared", 16'h0000, {8'h00, d});
      chk("irq cleared", 16'h0000, {15'h0, irq_seen});
      chk("vref_select", 16'(f + 1), {14'h0, vref_seen});
    end
    $display("conversions done");
    // Abort inside the sample period: nothing decided yet, so the result is zero.
    wr(OFS_MASK, 8'h02);
    wr(OFS_CONTROL, 8'h07);
    rd(OFS_CONTROL, d);
    wr(OFS_CONTROL, 8'h05);
    rd(OFS_CONTROL, d);
    chk("control after abort", 16'h0005, {8'h00, d});
    rd(OFS_STATUS, d);
    chk("abort status", 16'h0002, {8'h00, d});
    chk("abort irq", 16'h0001, {15'h0, irq_seen});
    rd(OFS_RES_HIGH, d);
    chk("abort high", 16'h0000, {8'h00, d});
    rd(OFS_RES_LOW, d);
    chk("abort low", 16'h0000, {8'h00, d});
    $display("abort done");
    end_of_test();
  end
endmodule // testbench
